// ### rtl/cspic_irq_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cspic_irq_decode
(
  // Select code
  input wire logic [3:0] sel,
  // Decoded lines
  output logic [15:0] lines,
  output logic smi
);
  // ==========================================
  // Code to line decode
  function automatic logic [15:0] lineOf(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    if (code != cspic_pkg::NIB_ZERO && code != 4'(cspic_pkg::SEL_SMI))
    begin
      v[code] = 1'b1;
    end
    return v;
  endfunction : lineOf

  always_comb
  begin
    lines = lineOf(sel);
    smi = (sel == 4'(cspic_pkg::SEL_SMI));
  end
endmodule : cspic_irq_decode
`default_nettype wire

// ### rtl/cspic_pkg.sv
`default_nettype none
package cspic_pkg;
  // ==========================================
  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LINE_N = 16;

  // ==========================================
  // Register addresses
  localparam logic [11:0] ADDR_MODEL = 12'h800;
  localparam logic [11:0] ADDR_POWER = 12'h802;
  localparam logic [11:0] ADDR_CTRL = 12'h803;
  localparam logic [11:0] ADDR_STAT = 12'h810;
  localparam logic [11:0] ADDR_MASK = 12'h811;

  // ==========================================
  // Reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  // Arbitrary model code selecting the alternate power layout
  localparam logic [3:0] MODEL_ALT = 4'h4;
  localparam logic [3:0] MODEL_RESET = 4'h4;

  // ==========================================
  // Power control fields
  localparam int PWR_OE = 7;
  localparam int PWR_AUTO = 5;
  localparam int PWR_EN = 4;
  localparam int PWR_VCC_HI = 4;
  localparam int PWR_VCC_LO = 3;
  localparam int PWR_VPP_HI = 1;
  localparam int PWR_VPP_LO = 0;
  localparam logic [1:0] VCC_0V = 2'h0;
  localparam logic [1:0] VCC_0V_RSVD = 2'h1;
  localparam logic [1:0] VCC_5V = 2'h2;
  localparam logic [1:0] VCC_3V3 = 2'h3;
  localparam logic [1:0] VPP_NONE = 2'h0;
  localparam logic [1:0] VPP_VCC = 2'h1;
  localparam logic [1:0] VPP_12V = 2'h2;

  // ==========================================
  // Interrupt and general control fields
  localparam int CTL_RING = 7;
  localparam int CTL_RST = 6;
  localparam int CTL_IO = 5;
  localparam int CTL_ROUTE = 4;
  localparam int CTL_SEL_HI = 3;
  localparam int SEL_SMI = 2;

  // ==========================================
  // Status and mask bits
  localparam int EV_N = 3;
  localparam int EV_CSC = 0;
  localparam int EV_RING = 1;
  localparam int EV_FUNC = 2;
endpackage : cspic_pkg
`default_nettype wire

// ### rtl/cspic_socket_ctrl.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cspic_socket_ctrl
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  // Card side
  input wire logic cardIs16,
  input wire logic batteryDetect1RingInput,
  input wire logic cardFuncIrq,
  input wire logic cardStatusChange,
  input wire logic [3:0] statusChangeIrqSelect,
  output logic cardOutputEnable,
  output logic cardResetAct,
  output logic ringMode,
  output logic cardKindIo,
  // Power switch
  output logic [1:0] vccSwitch,
  output logic [1:0] vppSwitch,
  // Routed interrupts
  output logic [15:0] isaIrq,
  output logic smiIrq,
  output logic pciIrq,
  output logic irq
);
  // ==========================================
  // Registers
  logic [7:0] powerReg_r, ctrlReg_r, rdData_r;
  logic [3:0] modelReg_r;
  logic [2:0] status_r, status_nxt, mask_r;
  logic [1:0] vcc_r, vpp_r, vccReq;
  logic ringPrev_r, oe_r, cardRst_r, ringMode_r, cardIo_r;
  logic [15:0] isa_r, funcLines, cscLines;
  logic smi_r, pci_r, irq_r;

  logic altModel, vccOn, cscToPci, funcSmi, cscSmi;
  logic [2:0] events, clearBits;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction : hit

  // ==========================================
  // Register writes
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      powerReg_r <= cspic_pkg::BYTE_ZERO;
      ctrlReg_r <= cspic_pkg::BYTE_ZERO;
      modelReg_r <= cspic_pkg::MODEL_RESET;
      mask_r <= 3'h0;
    end
    else if (wrStb)
    begin
      if (hit(addr, cspic_pkg::ADDR_POWER))
        powerReg_r <= wrData;
      if (hit(addr, cspic_pkg::ADDR_CTRL))
        ctrlReg_r <= wrData;
      if (hit(addr, cspic_pkg::ADDR_MODEL))
        modelReg_r <= wrData[3:0];
      if (hit(addr, cspic_pkg::ADDR_MASK))
        mask_r <= wrData[2:0];
    end
  end

  // ==========================================
  // Power decode
  always_comb
  begin
    altModel = (modelReg_r == cspic_pkg::MODEL_ALT);
    if (altModel)
    begin
      vccReq = powerReg_r[cspic_pkg::PWR_VCC_HI:cspic_pkg::PWR_VCC_LO];
    end
    else if (powerReg_r[cspic_pkg::PWR_EN])
    begin
      vccReq = cspic_pkg::VCC_5V;
    end
    else
    begin
      vccReq = cspic_pkg::VCC_0V;
    end
    vccOn = (vccReq == cspic_pkg::VCC_5V) || (vccReq == cspic_pkg::VCC_3V3);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      vcc_r <= cspic_pkg::VCC_0V;
      vpp_r <= cspic_pkg::VPP_NONE;
      oe_r <= 1'b0;
    end
    else
    begin
      vcc_r <= vccOn ? vccReq : cspic_pkg::VCC_0V;
      vpp_r <= vccOn ? powerReg_r[cspic_pkg::PWR_VPP_HI:
                                  cspic_pkg::PWR_VPP_LO]
                     : cspic_pkg::VPP_NONE;
      oe_r <= powerReg_r[cspic_pkg::PWR_OE];
    end
  end

  // ==========================================
  // Card control
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cardRst_r <= 1'b0;
      ringMode_r <= 1'b0;
      cardIo_r <= 1'b0;
    end
    else
    begin
      cardRst_r <= cardIs16 && !ctrlReg_r[cspic_pkg::CTL_RST];
      ringMode_r <= ctrlReg_r[cspic_pkg::CTL_RING];
      cardIo_r <= ctrlReg_r[cspic_pkg::CTL_IO];
    end
  end

  // ==========================================
  // Interrupt routing
  cspic_irq_decode uFunc
  (
    .sel(ctrlReg_r[cspic_pkg::CTL_SEL_HI:0]),
    .lines(funcLines),
    .smi(funcSmi)
  );

  cspic_irq_decode uCsc
  (
    .sel(statusChangeIrqSelect),
    .lines(cscLines),
    .smi(cscSmi)
  );

  assign cscToPci = ctrlReg_r[cspic_pkg::CTL_ROUTE] ||
    (ctrlReg_r[cspic_pkg::CTL_SEL_HI:0] == cspic_pkg::NIB_ZERO);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      isa_r <= 16'h0000;
      smi_r <= 1'b0;
      pci_r <= 1'b0;
    end
    else
    begin
      isa_r <= ({16{cardFuncIrq && cardIo_r}} & funcLines) |
               ({16{cardStatusChange && !cscToPci}} & cscLines);
      smi_r <= (cardFuncIrq && cardIo_r && funcSmi) ||
               (cardStatusChange && !cscToPci && cscSmi);
      pci_r <= cardStatusChange && cscToPci;
    end
  end

  // ==========================================
  // Event status and mask
  always_comb
  begin
    events = 3'h0;
    events[cspic_pkg::EV_CSC] = cardStatusChange;
    events[cspic_pkg::EV_RING] = ringMode_r && ringPrev_r &&
                                 !batteryDetect1RingInput;
    events[cspic_pkg::EV_FUNC] = cardFuncIrq && cardIo_r;
    clearBits = (wrStb && hit(addr, cspic_pkg::ADDR_STAT)) ?
                wrData[2:0] : 3'h0;
    status_nxt = (status_r & ~clearBits) | events;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      status_r <= 3'h0;
      ringPrev_r <= 1'b1;
      irq_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      ringPrev_r <= batteryDetect1RingInput;
      irq_r <= |(status_r & mask_r);
    end
  end

  // ==========================================
  // Register reads
  always_ff @(posedge clock)
  begin
    if (!rst_b || !rdStb)
    begin
      rdData_r <= cspic_pkg::BYTE_ZERO;
    end
    else if (hit(addr, cspic_pkg::ADDR_POWER))
    begin
      if (altModel)
      begin
        rdData_r <= {powerReg_r[cspic_pkg::PWR_OE], 2'b00,
                     powerReg_r[cspic_pkg::PWR_VCC_HI:cspic_pkg::PWR_VCC_LO],
                     1'b0,
                     powerReg_r[cspic_pkg::PWR_VPP_HI:cspic_pkg::PWR_VPP_LO]};
      end
      else
      begin
        rdData_r <= {powerReg_r[cspic_pkg::PWR_OE], 1'b0,
                     powerReg_r[cspic_pkg::PWR_AUTO:cspic_pkg::PWR_EN], 2'b00,
                     powerReg_r[cspic_pkg::PWR_VPP_HI:cspic_pkg::PWR_VPP_LO]};
      end
    end
    else if (hit(addr, cspic_pkg::ADDR_CTRL))
    begin
      rdData_r <= ctrlReg_r;
    end
    else if (hit(addr, cspic_pkg::ADDR_MODEL))
    begin
      rdData_r <= {4'h0, modelReg_r};
    end
    else if (hit(addr, cspic_pkg::ADDR_STAT))
    begin
      rdData_r <= {5'h00, status_r};
    end
    else if (hit(addr, cspic_pkg::ADDR_MASK))
    begin
      rdData_r <= {5'h00, mask_r};
    end
    else
    begin
      rdData_r <= cspic_pkg::BYTE_ZERO;
    end
  end

  assign rdData = rdData_r;
  assign cardOutputEnable = oe_r;
  assign cardResetAct = cardRst_r;
  assign ringMode = ringMode_r;
  assign cardKindIo = cardIo_r;
  assign vccSwitch = vcc_r;
  assign vppSwitch = vpp_r;
  assign isaIrq = isa_r;
  assign smiIrq = smi_r;
  assign pciIrq = pci_r;
  assign irq = irq_r;

  // ==========================================
  // Checks
  property p_oe;
    @(posedge clock) disable iff (!rst_b)
    wrStb && addr == cspic_pkg::ADDR_POWER ##1 !wrStb
      |-> ##1 cardOutputEnable == $past(wrData[7], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_vpp;
    @(posedge clock) disable iff (!rst_b)
    vppSwitch != cspic_pkg::VPP_NONE |-> vccSwitch[1];
  endproperty
  a_vpp: assert property (p_vpp) else $error("Vpp without Vcc");
  property p_rsvd;
    @(posedge clock) disable iff (!rst_b)
    rdStb && addr == cspic_pkg::ADDR_POWER && altModel
      |=> rdData[6:5] == 2'b00 && rdData[2] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_rst;
    @(posedge clock) disable iff (!rst_b)
    rst_b && cardIs16 && !ctrlReg_r[cspic_pkg::CTL_RST] |=> cardResetAct;
  endproperty
  a_rst: assert property (p_rst) else $error("card reset missing");
  property p_setwins;
    @(posedge clock) disable iff (!rst_b)
    cardStatusChange && wrStb && addr == cspic_pkg::ADDR_STAT && wrData[0]
      |=> status_r[cspic_pkg::EV_CSC];
  endproperty
  a_setwins: assert property (p_setwins) else $error("event lost");
  property p_irq;
    @(posedge clock) disable iff (!rst_b)
    (status_r & mask_r) != 3'h0 |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  property p_pci;
    @(posedge clock) disable iff (!rst_b)
    cardStatusChange && ctrlReg_r[cspic_pkg::CTL_ROUTE] |=> pciIrq &&
      (isaIrq == 16'h0000 && !smiIrq || $past(cardFuncIrq && cardIo_r));
  endproperty
  a_pci: assert property (p_pci) else $error("status change misrouted");
  property p_line4;
    @(posedge clock) disable iff (!rst_b)
    cardFuncIrq && cardIo_r && ctrlReg_r[3:0] == 4'h4 |=> isaIrq[4];
  endproperty
  a_line4: assert property (p_line4) else $error("line 4 missing");
  property p_zero;
    @(posedge clock) disable iff (!rst_b)
    ctrlReg_r[3:0] == 4'h0 && cardFuncIrq && !cardStatusChange
      |=> isaIrq == 16'h0000 && !smiIrq;
  endproperty
  a_zero: assert property (p_zero) else $error("select zero routed");
  property p_vcc;
    @(posedge clock) disable iff (!rst_b)
    altModel && powerReg_r[4:3] == cspic_pkg::VCC_0V_RSVD
      |=> vccSwitch == cspic_pkg::VCC_0V;
  endproperty
  a_vcc: assert property (p_vcc) else $error("reserved Vcc applied");
endmodule : cspic_socket_ctrl
`default_nettype wire

// ### testbench/card_socket_power_irq_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errTotal++; \
  $display("Error %0t value %h expected %h", $time, a, b); end end
module card_socket_power_irq_control_tb;
  // ====================
  // Signals
  logic clock, rst_b, wrStb, rdStb, cardIs16, cardStatusChange;
  logic ringCmd, irqCmd, batteryDetect1RingInput, cardFuncIrq;
  logic cardOutputEnable, cardResetAct, ringMode, cardKindIo;
  logic smiIrq, pciIrq, irq, rdSeen, route, s16, card_status_change, expSmi;
  logic [11:0] addr;
  logic [7:0] wrData, rdData, d, v;
  logic [3:0] scSel, sc;
  logic [1:0] vccSwitch, vppSwitch;
  logic [15:0] isaIrq, expIsa;
  logic [7:0] expQ[$];
  int errTotal, cmpCount, cyc;

  // ====================
  // Instances
  cspic_socket_ctrl dut (.clock(clock), .rst_b(rst_b), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .cardIs16(cardIs16), .batteryDetect1RingInput(batteryDetect1RingInput),
    .cardFuncIrq(cardFuncIrq), .cardStatusChange(cardStatusChange),
    .statusChangeIrqSelect(scSel), .cardOutputEnable(cardOutputEnable),
    .cardResetAct(cardResetAct), .ringMode(ringMode),
    .cardKindIo(cardKindIo), .vccSwitch(vccSwitch), .vppSwitch(vppSwitch),
    .isaIrq(isaIrq), .smiIrq(smiIrq), .pciIrq(pciIrq), .irq(irq));
  cspic_card_model card (.vccSwitch(vccSwitch),
    .cardOutputEnable(cardOutputEnable), .ringCmd(ringCmd),
    .irqCmd(irqCmd), .batteryDetect1RingInput(batteryDetect1RingInput),
    .cardFuncIrq(cardFuncIrq));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ====================
  // Tasks
  task automatic closeOut;
    if (errTotal == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : closeOut

  // One bus cycle; for reads x is the expected data
  task automatic acc(input logic w, input logic r, input logic [11:0] a,
    input logic [7:0] x);
    wrStb <= w;
    rdStb <= r;
    addr <= a;
    wrData <= x;
    if (r)
      expQ.push_back(x);
    @(posedge clock);
  endtask : acc

  task automatic idle(input int n);
    repeat (n) acc(1'b0, 1'b0, 12'h000, 8'h00);
  endtask : idle

  // ====================
  // Read monitor and timeout
  always @(posedge clock)
  begin
    if (rdSeen)
    begin
      v = expQ.pop_front();
      `CHK(rdData, v)
    end
    rdSeen <= rdStb;
    cyc++;
    if (cyc == 1000)
    begin
      errTotal++;
      closeOut;
    end
  end

  // ====================
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    {wrStb, rdStb, ringCmd, irqCmd, cardStatusChange} = '0;
    addr = 12'h000;
    wrData = 8'h00;
    cardIs16 = 1'b1;
    scSel = 4'h0;
    void'($urandom(9));
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    acc(1'b0, 1'b1, cspic_pkg::ADDR_POWER, 8'h00);
    acc(1'b0, 1'b1, cspic_pkg::ADDR_CTRL, 8'h00);
    acc(1'b0, 1'b1, cspic_pkg::ADDR_MODEL, 8'h04);
    acc(1'b1, 1'b0, 12'h7ff, 8'hff);
    acc(1'b0, 1'b1, 12'h7ff, 8'h00);
    idle(2);
    `CHK(cardResetAct, 1'b1)
    `CHK(cardOutputEnable, 1'b0)
    // Every Vcc and Vpp code, random other bits
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom());
      d[4:3] = i[3:2];
      d[1:0] = i[1:0];
      acc(1'b1, 1'b0, cspic_pkg::ADDR_POWER, d);
      acc(1'b0, 1'b1, cspic_pkg::ADDR_POWER,
        {d[7], 2'b00, d[4:3], 1'b0, d[1:0]});
      idle(1);
      `CHK(cardOutputEnable, d[7])
      `CHK(vccSwitch, (d[4:3] == 2'h1) ? 2'h0 : d[4:3])
      `CHK(vppSwitch, d[4] ? d[1:0] : 2'h0)
    end
    // Standard layout, then back
    acc(1'b1, 1'b0, cspic_pkg::ADDR_MODEL, 8'h01);
    acc(1'b1, 1'b0, cspic_pkg::ADDR_POWER, 8'hff);
    acc(1'b0, 1'b1, cspic_pkg::ADDR_POWER, 8'hb3);
    acc(1'b1, 1'b0, cspic_pkg::ADDR_MODEL, 8'h04);
    acc(1'b1, 1'b0, cspic_pkg::ADDR_POWER, 8'h90);
    irqCmd <= 1'b1;
    // Every select code for both card kinds
    for (int i = 0; i < 32; i++)
    begin
      d = 8'($urandom());
      d[3:0] = i[3:0];
      d[5] = i[4];
      sc = 4'($urandom());
      s16 = 1'($urandom());
      card_status_change = 1'($urandom());
      scSel <= sc;
      cardIs16 <= s16;
      cardStatusChange <= card_status_change;
      acc(1'b1, 1'b0, cspic_pkg::ADDR_CTRL, d);
      acc(1'b0, 1'b1, cspic_pkg::ADDR_CTRL, d);
      idle(1);
      route = d[4] | (d[3:0] == 4'h0);
      expIsa = 16'h0000;
      if (d[5] && d[3:0] != 4'h0 && d[3:0] != 4'h2)
        expIsa[d[3:0]] = 1'b1;
      if (card_status_change && !route && sc != 4'h0 && sc != 4'h2)
        expIsa[sc] = 1'b1;
      expSmi = (d[5] && d[3:0] == 4'h2) ||
               (card_status_change && !route && sc == 4'h2);
      `CHK(isaIrq, expIsa)
      `CHK(smiIrq, expSmi)
      `CHK(pciIrq, card_status_change & route)
      `CHK(ringMode, d[7])
      `CHK(cardKindIo, d[5])
      `CHK(cardResetAct, ~d[6] & s16)
    end
    // Ring event: status, mask, clear
    irqCmd <= 1'b0;
    cardStatusChange <= 1'b0;
    acc(1'b1, 1'b0, cspic_pkg::ADDR_CTRL, 8'h80);
    acc(1'b1, 1'b0, cspic_pkg::ADDR_MASK, 8'h00);
    idle(3);
    acc(1'b1, 1'b0, cspic_pkg::ADDR_STAT, 8'h07);
    ringCmd <= 1'b1;
    idle(1);
    ringCmd <= 1'b0;
    idle(3);
    `CHK(irq, 1'b0)
    acc(1'b0, 1'b1, cspic_pkg::ADDR_STAT, 8'h02);
    acc(1'b1, 1'b0, cspic_pkg::ADDR_MASK, 8'h02);
    idle(3);
    `CHK(irq, 1'b1)
    acc(1'b1, 1'b0, cspic_pkg::ADDR_STAT, 8'h02);
    idle(3);
    `CHK(irq, 1'b0)
    acc(1'b0, 1'b1, cspic_pkg::ADDR_STAT, 8'h00);
    idle(2);
    // Mid-run reset, then set beats clear
    rst_b <= 1'b0;
    idle(3);
    rst_b <= 1'b1;
    acc(1'b0, 1'b1, cspic_pkg::ADDR_POWER, 8'h00);
    `CHK(cardOutputEnable, 1'b0)
    `CHK(vccSwitch, 2'h0)
    cardStatusChange <= 1'b1;
    acc(1'b1, 1'b0, cspic_pkg::ADDR_STAT, 8'h01);
    cardStatusChange <= 1'b0;
    acc(1'b0, 1'b1, cspic_pkg::ADDR_STAT, 8'h01);
    idle(2);
    closeOut;
  end
endmodule : card_socket_power_irq_control_tb
`default_nettype wire

// ### testbench/cspic_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Card and power switch
module cspic_card_model
(
  // Switch side
  input wire logic [1:0] vccSwitch,
  input wire logic cardOutputEnable,
  // Bench commands
  input wire logic ringCmd,
  input wire logic irqCmd,
  // Card pins
  output logic batteryDetect1RingInput,
  output logic cardFuncIrq
);
  // Card raises its irq only while powered and enabled
  assign cardFuncIrq = irqCmd & vccSwitch[1] & cardOutputEnable;
  assign batteryDetect1RingInput = ~ringCmd;
endmodule : cspic_card_model
`default_nettype wire
